/* File: rtl/fbo_host.sv */
// Host controller driving a banked asynchronous NOR flash bus
//
// Contract
// - Reads drive select and output gate low, write strobe high.
// - Command writes drive write strobe and select low, gate high.
// - Shortened program mode needs two write cycles, not four.
// - Boost only while programming; otherwise pin held at supply; this controller does not enforce it, the pin is control bits protect OR boost.
// - Host waits recovery delay after init high before reading.
// - Host reissues an aborted operation once device accepts commands; this controller does not, software resends it.
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/100ps
module fbo_host
   import fbo_pkg::*;
#(
   parameter int unsigned ACCESS_CYC = fbo_pkg::ADDR_TO_DATA_CYC,
   parameter int unsigned PAGE_CYC   = fbo_pkg::IN_PAGE_CYC
) (
   // Clock and reset
   input  wire logic                        ref_clk,
   input  wire logic                        rst,
   // Software register port
   input  wire logic [fbo_pkg::REG_AW-1:0]  reg_addr,
   input  wire logic [fbo_pkg::REG_DW-1:0]  reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [fbo_pkg::REG_DW-1:0]  reg_rdata,
   // Flash control pins
   output logic                             flash_sel_n,
   output logic                             flash_gate_n,
   output logic                             flash_wr_n,
   output logic                             flash_init_n,
   output logic      [fbo_pkg::ADDR_W-1:0]  flash_addr,
   // Flash data bus, two-way
   input  wire logic [fbo_pkg::DATA_W-1:0]  flash_dq_in,
   output logic      [fbo_pkg::DATA_W-1:0]  flash_dq_out,
   output logic                             flash_dq_oe,
   // Protect pin: logic level plus separate boost qualifier
   output logic                             protect_boost_pin,
   output logic                             boost_voltage_level,
   // Busy line from the flash, open drain, low while busy
   input  wire logic                        busy_flag_n
);
   import fbo_pkg::*;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   // Bus phases; one transfer at a time, software polls for idle
   typedef enum logic [2:0] {
      S_IDLE, S_READ, S_WR_LOW, S_WR_HIGH, S_INIT, S_RECOVER
   } fbo_phase_t;

   // Whole controller state in one record, registered as a unit
   typedef struct packed {
      fbo_phase_t               phase;
      logic [CNT_W-1:0]         cnt;
      logic [ADDR_W-1:0]        addr;
      logic [DATA_W-1:0]        wdata;
      logic [DATA_W-1:0]        rdata;
      logic                     sel_n;
      logic                     gate_n;
      logic                     wr_n;
      logic                     init_n;
      logic                     dq_oe;
      logic                     page_ok;
      logic [ADDR_W-1:PAGE_LSB] page;
      logic                     protect;
      logic                     boost;
      logic [REG_DW-1:0]        rd_q;
   } fbo_state_t;

   fbo_state_t st_ff;
   fbo_state_t nxt_st;
   logic       busy_sync_n;

   // ------------------------------------------------------------
   // Busy line synchroniser
   // ------------------------------------------------------------
   fbo_sync u_busy_sync (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .pin_in    (busy_flag_n),
      .level_out (busy_sync_n)
   );

   // Bank decode used by the status register
   function automatic fbo_bank_t bank_of(input logic [ADDR_W-1:0] a);
      logic [2:0] hi;
      hi = a[ADDR_W-1:BANK_LSB];
      if (hi == 3'h0) begin
         bank_of = FBO_BANK_A;
      end else if (hi == 3'h7) begin
         bank_of = FBO_BANK_D;
      end else if (hi[2] == 1'b0) begin
         bank_of = FBO_BANK_B;
      end else begin
         bank_of = FBO_BANK_C;
      end
   endfunction

   // Truncate a timing constant to the counter width; only an input of zero is raised to one
   function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
      cyc = (n < 1) ? CNT_W'(1) : CNT_W'(n);
   endfunction

   // True when the low two bits of the written word match the command code
   function automatic logic cmd_is(input logic [1:0] code,
                                   input logic [REG_DW-1:0] w);
      cmd_is = (w[1:0] == code);
   endfunction

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      // Register writes; commands only accepted while idle
      if (reg_wr) begin
         unique case (reg_addr)
            REG_ADDR: begin
               nxt_st.addr = reg_wdata[ADDR_W-1:0];
            end
            REG_WDATA: begin
               nxt_st.wdata = reg_wdata[DATA_W-1:0];
            end
            REG_CTRL: begin
               nxt_st.protect = reg_wdata[CTRL_PROTECT_BIT];
               nxt_st.boost   = reg_wdata[CTRL_BOOST_BIT];
            end
            default: begin
            end
         endcase
      end
      // Boost stays under software control; the reset command also clears it
      unique case (st_ff.phase)
         S_IDLE: begin
            // One command per idle period; busy-time commands are dropped
            if (reg_wr && reg_addr == REG_CMD) begin
               if (cmd_is(CMD_READ, reg_wdata)) begin
                  // Same page with chip still selected: short delay
                  // A dropped select in between forces the full delay
                  if (st_ff.page_ok && !st_ff.sel_n &&
                      st_ff.page == st_ff.addr[ADDR_W-1:PAGE_LSB]) begin
                     nxt_st.cnt = cyc(PAGE_CYC);
                  end else begin
                     nxt_st.cnt = cyc(ACCESS_CYC);
                  end
                  nxt_st.sel_n  = 1'b0;
                  nxt_st.gate_n = 1'b0;
                  nxt_st.wr_n   = 1'b1;
                  nxt_st.dq_oe  = 1'b0;
                  nxt_st.phase  = S_READ;
               end else if (cmd_is(CMD_WRITE, reg_wdata)) begin
                  // One bus cycle per command; software sends the
                  // two or four cycles of a program sequence itself
                  nxt_st.gate_n  = 1'b1;
                  nxt_st.sel_n   = 1'b0;
                  nxt_st.wr_n    = 1'b0;
                  nxt_st.dq_oe   = 1'b1;
                  nxt_st.page_ok = 1'b0;
                  nxt_st.cnt     = cyc(WRITE_PULSE_CYC);
                  nxt_st.phase   = S_WR_LOW;
               end else if (cmd_is(CMD_RESET, reg_wdata)) begin
                  // Boost dropped so the high level never outlives
                  // an aborted operation
                  nxt_st.init_n  = 1'b0;
                  nxt_st.sel_n   = 1'b1;
                  nxt_st.gate_n  = 1'b1;
                  nxt_st.boost   = 1'b0;
                  nxt_st.page_ok = 1'b0;
                  nxt_st.cnt     = cyc(INIT_PULSE_CYC);
                  nxt_st.phase   = S_INIT;
               end
            end
         end
         S_READ: begin
            // Count down the access time chosen at the command
            if (st_ff.cnt > CNT_W'(1)) begin
               nxt_st.cnt = st_ff.cnt - CNT_W'(1);
            end else begin
               // Sample data; keep select low so the page stays open
               nxt_st.rdata   = flash_dq_in;
               nxt_st.gate_n  = 1'b1;
               nxt_st.page    = st_ff.addr[ADDR_W-1:PAGE_LSB];
               nxt_st.page_ok = 1'b1;
               nxt_st.phase   = S_IDLE;
            end
         end
         S_WR_LOW: begin
            // Write strobe held low for the pulse width
            if (st_ff.cnt > CNT_W'(1)) begin
               nxt_st.cnt = st_ff.cnt - CNT_W'(1);
            end else begin
               // Rising write strobe latches the data word
               nxt_st.wr_n  = 1'b1;
               nxt_st.cnt   = cyc(WRITE_HIGH_CYC);
               nxt_st.phase = S_WR_HIGH;
            end
         end
         S_WR_HIGH: begin
            // Select and data kept while the hold time runs
            if (st_ff.cnt > CNT_W'(1)) begin
               nxt_st.cnt = st_ff.cnt - CNT_W'(1);
            end else begin
               // Deselect is safe: a started operation runs on
               nxt_st.sel_n = 1'b1;
               nxt_st.dq_oe = 1'b0;
               nxt_st.phase = S_IDLE;
            end
         end
         S_INIT: begin
            // Init held low for at least the minimum pulse width
            if (st_ff.cnt > CNT_W'(1)) begin
               nxt_st.cnt = st_ff.cnt - CNT_W'(1);
            end else begin
               nxt_st.init_n = 1'b1;
               nxt_st.cnt    = cyc(INIT_TO_READ_CYC);
               nxt_st.phase  = S_RECOVER;
            end
         end
         S_RECOVER: begin
            // Wait recovery, then for busy high: reset done
            if (st_ff.cnt > CNT_W'(1)) begin
               nxt_st.cnt = st_ff.cnt - CNT_W'(1);
            end else if (busy_sync_n) begin
               // Commands accepted again; software must resend aborted work
               nxt_st.phase = S_IDLE;
            end
         end
         default: begin
            nxt_st.phase = S_IDLE;
         end
      endcase
      // Registered read data for the software port
      // Zero outside the read slot and for unmapped indices
      nxt_st.rd_q = '0;
      if (reg_rd) begin
         unique case (reg_addr)
            REG_ADDR:   nxt_st.rd_q = REG_DW'(st_ff.addr);
            REG_WDATA:  nxt_st.rd_q = REG_DW'(st_ff.wdata);
            REG_RDATA:  nxt_st.rd_q = REG_DW'(st_ff.rdata);
            REG_CTRL: begin
               nxt_st.rd_q[CTRL_PROTECT_BIT] = st_ff.protect;
               nxt_st.rd_q[CTRL_BOOST_BIT]   = st_ff.boost;
            end
            REG_STATUS: begin
               nxt_st.rd_q[ST_BUSY_BIT]    = (st_ff.phase != S_IDLE);
               nxt_st.rd_q[ST_FLASH_BIT]   = ~busy_sync_n;
               nxt_st.rd_q[ST_PAGEHIT_BIT] = st_ff.page_ok;
               nxt_st.rd_q[ST_BANK_LSB +: 2] = bank_of(st_ff.addr);
            end
            default:    nxt_st.rd_q = '0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // State register: flash deselected, init released at reset
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_ff         <= '0;
         st_ff.phase   <= S_IDLE;
         st_ff.sel_n   <= 1'b1;
         st_ff.gate_n  <= 1'b1;
         st_ff.wr_n    <= 1'b1;
         st_ff.init_n  <= 1'b1;
         st_ff.protect <= CTRL_RESET_VAL[CTRL_PROTECT_BIT];
         st_ff.boost   <= CTRL_RESET_VAL[CTRL_BOOST_BIT];
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------------------
   // Outputs, all from flops
   // ------------------------------------------------------------
   assign reg_rdata           = st_ff.rd_q;
   assign flash_sel_n         = st_ff.sel_n;
   assign flash_gate_n        = st_ff.gate_n;
   assign flash_wr_n          = st_ff.wr_n;
   assign flash_init_n        = st_ff.init_n;
   assign flash_addr          = st_ff.addr;
   assign flash_dq_out        = st_ff.wdata;
   assign flash_dq_oe         = st_ff.dq_oe;
   // Pin is protect OR boost; boost qualifier also on its own output
   assign protect_boost_pin   = st_ff.protect | st_ff.boost;
   assign boost_voltage_level = st_ff.boost;
endmodule

/* File: rtl/fbo_pkg.sv */
// Package of constants and types for the flash bus host controller
package fbo_pkg;
   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_PS      = 4000;
   localparam int unsigned ADDR_TO_DATA_NS    = 70;
   localparam int unsigned SELECT_TO_DATA_NS  = 70;
   localparam int unsigned IN_PAGE_NS         = 25;
   localparam int unsigned INIT_PULSE_MIN_NS  = 500;
   localparam int unsigned INIT_TO_READ_NS    = 50;
   localparam int unsigned WRITE_PULSE_NS     = 35;
   localparam int unsigned WRITE_HIGH_NS      = 30;
   // Least times round up to whole cycles
   localparam int unsigned ADDR_TO_DATA_CYC =
      (ADDR_TO_DATA_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned SELECT_TO_DATA_CYC =
      (SELECT_TO_DATA_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned IN_PAGE_CYC =
      (IN_PAGE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned INIT_PULSE_CYC =
      (INIT_PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned INIT_TO_READ_CYC =
      (INIT_TO_READ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned WRITE_PULSE_CYC =
      (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned WRITE_HIGH_CYC =
      (WRITE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned CNT_W = 8;

   // ---------------------------------------------------------------
   // Widths and address fields
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W     = 22;
   localparam int unsigned DATA_W     = 16;
   localparam int unsigned PAGE_LSB   = 3;
   localparam int unsigned BANK_LSB   = 19;
   localparam int unsigned REG_AW     = 4;
   localparam int unsigned REG_DW     = 32;

   // ---------------------------------------------------------------
   // Software register map (word indices)
   // ---------------------------------------------------------------
   localparam logic [REG_AW-1:0] REG_ADDR   = 4'h0;
   localparam logic [REG_AW-1:0] REG_WDATA  = 4'h1;
   localparam logic [REG_AW-1:0] REG_CMD    = 4'h2;
   localparam logic [REG_AW-1:0] REG_STATUS = 4'h3;
   localparam logic [REG_AW-1:0] REG_RDATA  = 4'h4;
   localparam logic [REG_AW-1:0] REG_CTRL   = 4'h5;

   // Command codes written to REG_CMD
   localparam logic [1:0] CMD_READ  = 2'h1;
   localparam logic [1:0] CMD_WRITE = 2'h2;
   localparam logic [1:0] CMD_RESET = 2'h3;

   // Control register fields
   localparam int unsigned CTRL_PROTECT_BIT = 0;
   localparam int unsigned CTRL_BOOST_BIT   = 1;
   localparam logic [1:0]  CTRL_RESET_VAL   = 2'h1;

   // Status register fields
   localparam int unsigned ST_BUSY_BIT    = 0;
   localparam int unsigned ST_FLASH_BIT   = 1;
   localparam int unsigned ST_PAGEHIT_BIT = 2;
   localparam int unsigned ST_BANK_LSB    = 4;

   // Bank codes
   typedef enum logic [1:0] {
      FBO_BANK_A, FBO_BANK_B, FBO_BANK_C, FBO_BANK_D
   } fbo_bank_t;
endpackage

/* File: rtl/fbo_sync.sv */
// Three-flop synchroniser with agreement filter for one pin
`timescale 1ns/100ps
module fbo_sync (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // Pin and filtered level
   input  wire logic pin_in,
   output logic      level_out
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } fbo_sync_state_t;

   fbo_sync_state_t st_ff;
   fbo_sync_state_t nxt_st;

   // Shift chain; level changes only when flops two and three agree
   always_comb begin
      nxt_st     = st_ff;
      nxt_st.s1  = pin_in;
      nxt_st.s2  = st_ff.s1;
      nxt_st.s3  = st_ff.s2;
      if (st_ff.s2 == st_ff.s3) begin
         nxt_st.lvl = st_ff.s3;
      end
   end

   // Reset to the idle-high level of an open-drain busy line
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_ff <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b1};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign level_out = st_ff.lvl;
endmodule

/* File: tb/fbo_flash_model.sv */
// Behavioural model of the banked flash on the far side
`timescale 1ns/100ps
module fbo_flash_model #(
   parameter int unsigned ACC_CYC  = 18,
   parameter int unsigned PAGE_CYC = 7,
   parameter int unsigned BUSY_CYC = 100,
   parameter int unsigned RDY_CYC  = 20
) (
   // Clock
   input  wire logic        ref_clk,
   // Pins from the controller
   input  wire logic        flash_sel_n,
   input  wire logic        flash_gate_n,
   input  wire logic        flash_wr_n,
   input  wire logic        flash_init_n,
   input  wire logic [21:0] flash_addr,
   input  wire logic [15:0] flash_dq_out,
   input  wire logic        flash_dq_oe,
   // Wire level of data bus and busy line
   output logic      [15:0] flash_dq_in,
   output logic             busy_flag_n
);
   logic [15:0] mem [logic [21:0]];
   logic [15:0] junk = 16'h3c3c;
   logic [7:0]  cnt = 8'h00;
   logic [7:0]  busy = 8'h00;
   logic [18:0] pg = 19'h0;
   logic        open = 1'b0;
   logic        armed = 1'b0;
   logic        keep = 1'b0;
   logic        wr_d = 1'b1;
   logic        gate_d = 1'b1;
   logic [21:0] p_a;
   logic [15:0] p_d;
   logic        ready;

   function automatic logic [15:0] patt(input logic [21:0] a);
      return a[15:0] ^ 16'h5a5a;
   endfunction

   // Page hit only while select stayed low since the last read
   assign ready = cnt >= ((open && flash_addr[21:3] == pg) ?
      PAGE_CYC - 1 : ACC_CYC - 1);
   assign busy_flag_n = (busy == 8'h00);

   // Mid-cycle bus level; idle bus toggles so stale data never passes
   always @(negedge ref_clk) begin
      if (flash_dq_oe)
         flash_dq_in <= flash_dq_out;
      else if (!flash_sel_n && !flash_gate_n && flash_init_n && ready)
         flash_dq_in <= mem.exists(flash_addr) ?
            mem[flash_addr] : patt(flash_addr);
      else
         flash_dq_in <= junk;
   end

   // Access timing, page state and embedded program
   always @(posedge ref_clk) begin
      junk   <= ~junk;
      gate_d <= flash_gate_n;
      wr_d   <= flash_wr_n;
      cnt    <= (flash_sel_n || flash_gate_n) ? 8'h00 : cnt + 8'h01;
      if (flash_sel_n) begin
         open <= 1'b0;
      end else if (flash_gate_n && !gate_d) begin
         open <= 1'b1;
         pg   <= flash_addr[21:3];
      end
      if (!flash_init_n) begin
         if (busy != 8'h00)
            busy <= 8'(RDY_CYC);
         keep  <= 1'b0;
         armed <= 1'b0;
      end else if (flash_wr_n && !wr_d && !flash_sel_n) begin
         armed <= (flash_dq_out == 16'h00a0);
         if (armed) begin
            busy <= 8'(BUSY_CYC);
            p_a  <= flash_addr;
            p_d  <= flash_dq_out;
            keep <= 1'b1;
         end
      end else if (busy != 8'h00) begin
         busy <= busy - 8'h01;
         if (busy == 8'h01 && keep)
            mem[p_a] = p_d;
      end
   end
endmodule

/* File: tb/fbo_host_asserts.sv */
// Checker of the flash pin protocol at the controller ports
`timescale 1ns/100ps
module fbo_host_asserts #(
   parameter int unsigned ACCESS_CYC = 18,
   parameter int unsigned PAGE_CYC   = 7
) (
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        rst,
   // Register read path
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   // Flash pins
   input wire logic        flash_sel_n,
   input wire logic        flash_gate_n,
   input wire logic        flash_wr_n,
   input wire logic        flash_init_n,
   input wire logic        flash_dq_oe,
   input wire logic        protect_boost_pin,
   input wire logic        boost_voltage_level
);
   localparam int GM1   = PAGE_CYC - 1;
   localparam int GSPAN = ACCESS_CYC - PAGE_CYC + 1;
   logic [7:0] low_cnt;

   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // ------------------------------------------
   // Helper logic
   // ------------------------------------------
   // Init pulse length; cleared while high so each pulse counts alone
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         low_cnt <= 8'h00;
      else if (!flash_init_n)
         low_cnt <= low_cnt + 8'h01;
      else
         low_cnt <= 8'h00;
   end

   // Read strobe held at least the in-page time
   sequence gate_min_low;
      !flash_gate_n throughout ##GM1 1'b1;
   endsequence
   // Write strobe pulse, then select held past it
   sequence write_hold;
      (!flash_wr_n)[*8] ##1 (!flash_sel_n)[*7];
   endsequence

   // ------------------------------------------
   // Assertions
   // ------------------------------------------
   read_pins_a: assert property (
      !flash_sel_n && !flash_gate_n |-> flash_wr_n)
      else $error("write strobe low during read");
   write_pins_a: assert property (
      !flash_wr_n |-> !flash_sel_n && flash_gate_n && flash_dq_oe)
      else $error("bad pins during write");
   write_pulse_a: assert property (
      $fell(flash_wr_n) |-> write_hold)
      else $error("write pulse or hold too short");
   read_time_a: assert property (
      $fell(flash_gate_n) |-> gate_min_low ##[1:GSPAN] flash_gate_n)
      else $error("read gate length out of range");
   page_open_a: assert property (
      $rose(flash_gate_n) && flash_init_n |-> !flash_sel_n)
      else $error("select released after read");
   init_len_a: assert property (
      $rose(flash_init_n) |-> low_cnt >= fbo_pkg::INIT_PULSE_CYC)
      else $error("init pulse too short");
   init_quiet_a: assert property (
      !flash_init_n |-> flash_sel_n && flash_gate_n && flash_wr_n
         && !flash_dq_oe && !boost_voltage_level)
      else $error("access during init pulse");
   recover_wait_a: assert property (
      $rose(flash_init_n) |-> flash_gate_n[*8])
      else $error("read too soon after init");
   boost_level_a: assert property (
      boost_voltage_level |-> protect_boost_pin)
      else $error("boost without protect level high");
   rdata_slot_a: assert property (
      !$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside its slot");
endmodule

/* File: tb/fbo_host_tb.sv */
// Self-checking bench of the flash host controller
`timescale 1ns/100ps
module fbo_host_tb;
   import fbo_pkg::*;
   localparam int unsigned ACC = ADDR_TO_DATA_CYC;
   localparam int unsigned PG  = IN_PAGE_CYC;
   logic              ref_clk = 1'b0;
   logic              rst = 1'b1;
   logic [REG_AW-1:0] reg_addr = 4'h0;
   logic [REG_DW-1:0] reg_wdata = 32'h0;
   logic              reg_wr = 1'b0;
   logic              reg_rd = 1'b0;
   logic [REG_DW-1:0] reg_rdata;
   logic              flash_sel_n, flash_gate_n, flash_wr_n, flash_init_n;
   logic [ADDR_W-1:0] flash_addr;
   logic [DATA_W-1:0] flash_dq_in, flash_dq_out;
   logic              flash_dq_oe, protect_boost_pin, boost_voltage_level;
   logic              busy_flag_n;
   logic [31:0]       exp_q[$], msk_q[$];
   logic [31:0]       e, m;
   logic              rd_d = 1'b0;
   logic              gd = 1'b1;
   logic [7:0]        glow = 8'h0;
   logic [1:0]        bk [8] = '{2'h0, 2'h1, 2'h1, 2'h1,
                                 2'h2, 2'h2, 2'h2, 2'h3};
   logic [21:0]       a;
   int                miscompares = 0;
   int                checks = 0;
   int                cyc = 0;
   integer            seed = 18704;

   always #2 ref_clk = ~ref_clk;

   fbo_host #(.ACCESS_CYC(ACC), .PAGE_CYC(PG)) dut (.ref_clk, .rst,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .flash_sel_n,
      .flash_gate_n, .flash_wr_n, .flash_init_n, .flash_addr, .flash_dq_in,
      .flash_dq_out, .flash_dq_oe, .protect_boost_pin,
      .boost_voltage_level, .busy_flag_n);
   fbo_flash_model #(.ACC_CYC(ACC), .PAGE_CYC(PG)) mdl (.ref_clk,
      .flash_sel_n, .flash_gate_n, .flash_wr_n, .flash_init_n, .flash_addr,
      .flash_dq_out, .flash_dq_oe, .flash_dq_in, .busy_flag_n);

   // ------------------------------------------
   // Register bus and flash operation tasks
   // ------------------------------------------
   task automatic wr(input logic [3:0] ad, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr  <= ad;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask
   // Mask of zero marks a poll that nobody compares
   task automatic rd(input logic [3:0] ad, input logic [31:0] ex, mk);
      exp_q.push_back(ex);
      msk_q.push_back(mk);
      @(posedge ref_clk);
      reg_addr <= ad;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
   endtask
   task automatic idle(input int b);
      int n;
      n = 0;
      do begin
         rd(REG_STATUS, 32'h0, 32'h0);
         #1;
         n++;
      end while (reg_rdata[b] !== 1'b0 && n < 400);
      if (reg_rdata[b] !== 1'b0) begin
         miscompares++;
         $display("[ERR] %0t wait for idle timed out", $time);
      end
   endtask
   task automatic fread(input logic [21:0] ad, input logic [15:0] ex,
                        input logic [7:0] n);
      wr(REG_ADDR, {10'h0, ad});
      wr(REG_CMD, {30'h0, CMD_READ});
      idle(0);
      checks++;
      if (glow !== n) begin
         miscompares++;
         $display("[ERR] %0t gate low %0d cycles, not %0d", $time, glow, n);
      end
      rd(REG_RDATA, {16'h0, ex}, 32'hffffffff);
   endtask
   task automatic fwrite(input logic [21:0] ad, input logic [15:0] d);
      wr(REG_ADDR, {10'h0, ad});
      wr(REG_WDATA, {16'h0, d});
      wr(REG_CMD, {30'h0, CMD_WRITE});
      idle(0);
   endtask
   // Level check of a pin that no register read reflects
   task automatic pin_chk(input logic got, input logic ex);
      checks++;
      if (got !== ex) begin
         miscompares++;
         $display("[ERR] %0t pin %b, expected %b", $time, got, ex);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ------------------------------------------
   // Result monitor, gate timer and timeout
   // ------------------------------------------
   always @(posedge ref_clk) begin
      if (rd_d && msk_q.size() > 0) begin
         e = exp_q.pop_front();
         m = msk_q.pop_front();
         if (m != 32'h0) begin
            checks++;
            if ((reg_rdata & m) !== (e & m)) begin
               miscompares++;
               $display("[ERR] %0t read %h, expected %h", $time, reg_rdata, e);
            end
         end
      end
      rd_d <= reg_rd;
      gd   <= flash_gate_n;
      glow <= !flash_gate_n ? (gd ? 8'h1 : glow + 8'h1) : glow;
      cyc++;
      if (cyc == 40000) begin
         miscompares++;
         finish_test();
      end
   end

   // ------------------------------------------
   // Main sequence
   // ------------------------------------------
   initial begin
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      rd(REG_CTRL, 32'h1, 32'hffffffff);
      rd(REG_STATUS, 32'h0, 32'h7);
      rd(4'hf, 32'h0, 32'hffffffff);
      a = 22'($random(seed)) & 22'h3ffff8;
      fread(a | 22'h5, mdl.patt(a | 22'h5), 8'(ACC));
      rd(REG_STATUS, 32'h4, 32'h4);
      for (int w = 0; w < 8; w++)
         fread(a | 22'(w), mdl.patt(a | 22'(w)), 8'(PG));
      fread(a ^ 22'h8, mdl.patt(a ^ 22'h8), 8'(ACC));
      for (int b = 0; b < 8; b++) begin
         wr(REG_ADDR, {10'h0, 3'(b), 19'h0});
         rd(REG_STATUS, {26'h0, bk[b], 4'h0}, 32'h30);
      end
      fwrite(22'h000010, 16'h00a0);
      fwrite(22'h000010, 16'hbeef);
      rd(REG_STATUS, 32'h2, 32'h6);
      fread(22'h3f0000, mdl.patt(22'h3f0000), 8'(ACC));
      idle(1);
      fread(22'h000010, 16'hbeef, 8'(ACC));
      wr(REG_CTRL, 32'h3);
      rd(REG_CTRL, 32'h3, 32'h3);
      pin_chk(boost_voltage_level, 1'b1);
      pin_chk(protect_boost_pin, 1'b1);
      fwrite(22'h200020, 16'h00a0);
      fwrite(22'h200020, 16'h1234);
      wr(REG_CMD, {30'h0, CMD_RESET});
      idle(0);
      rd(REG_STATUS, 32'h0, 32'h2);
      rd(REG_CTRL, 32'h1, 32'h3);
      pin_chk(boost_voltage_level, 1'b0);
      pin_chk(protect_boost_pin, 1'b1);
      fread(22'h200020, mdl.patt(22'h200020), 8'(ACC));
      fwrite(22'h200020, 16'h00a0);
      fwrite(22'h200020, 16'h1234);
      idle(1);
      fread(22'h200020, 16'h1234, 8'(ACC));
      repeat (3) @(posedge ref_clk);
      finish_test();
   end
endmodule

bind fbo_host fbo_host_asserts #(.ACCESS_CYC(ACCESS_CYC),
   .PAGE_CYC(PAGE_CYC)) chk (.ref_clk, .rst, .reg_rd, .reg_rdata,
   .flash_sel_n, .flash_gate_n, .flash_wr_n, .flash_init_n, .flash_dq_oe,
   .protect_boost_pin, .boost_voltage_level);
